// File: logic/tct_pkg.sv
`default_nettype none
package tct_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] OFS_TAP1 = 8'h34;
  localparam logic [7:0] OFS_CLOCK = 8'h40;
  localparam logic [7:0] OFS_TUNER = 8'h44;
  localparam logic [7:0] OFS_EV_SET = 8'h48;
  localparam logic [7:0] OFS_EV_CLR = 8'h4c;
  localparam logic [7:0] OFS_EV_STATE = 8'h50;
  localparam logic [7:0] OFS_CALENDAR = 8'h54;
  localparam logic [7:0] OFS_PARAMS = 8'hf0;
  localparam logic [7:0] OFS_REVISION = 8'hfc;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions and widths.
  localparam int TAP_W = 5;
  localparam int CLK_EN_BIT = 0;
  localparam int SRC_LSB = 8;
  localparam int SRC_W = 3;
  localparam int EXP_LSB = 0;
  localparam int EXP_W = 5;
  localparam int ADD_BIT = 5;
  localparam int MAG_LSB = 8;
  localparam int MAG_W = 8;
  localparam int EV_OVF_BIT = 0;
  localparam int EV_ALARM_BIT = 8;
  localparam int EV_PER_BIT = 16;
  localparam int TUNE_CNT_W = 40;

  // Calendar field layout.
  localparam int SEC_LSB = 0;
  localparam int MIN_LSB = 6;
  localparam int HOUR_LSB = 12;
  localparam int DAY_LSB = 17;
  localparam int MON_LSB = 22;
  localparam int YEAR_LSB = 26;
  localparam logic [5:0] SEC_MAX = 6'h3b;
  localparam logic [5:0] MIN_MAX = 6'h3b;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [4:0] DAY_MIN = 5'h01;
  localparam logic [3:0] MON_MIN = 4'h1;
  localparam logic [3:0] MON_MAX = 4'hc;

  // Mask of implemented event bits.
  localparam logic [31:0] EV_MASK_BITS = 32'h00010101;

  ////////////////////////////////////////////////////////////////////////////////
  // Build configuration; the parameter register is assembled from these.
  localparam logic TAP0_WRITABLE = 1'b1;
  localparam logic TAP1_WRITABLE = 1'b0;
  localparam logic [4:0] TAP0_FIXED = 5'h00;
  localparam logic [4:0] TAP1_FIXED = 5'h00;
  localparam logic EXP_WRITABLE = 1'b1;
  localparam logic [4:0] EXP_FIXED = 5'h00;
  localparam logic PERIODIC_COUNT_CODE = 1'b0;
  localparam logic [1:0] ALARM_COUNT_CODE = 2'h1;
  localparam logic TUNER_PRESENT = 1'b1;
  // Revision value is arbitrary.
  localparam logic [31:0] REVISION_VALUE = 32'h00000100;

  // Prescaler source codes.
  typedef enum logic [2:0] {
    SRC_RC_SYS = 3'h0,
    SRC_OSC_32K = 3'h1,
    SRC_BUS_CLK = 3'h2,
    SRC_GENERIC = 3'h3,
    SRC_ONE_KHZ = 3'h4
  } tct_src_t;

  // Raw event inputs from the counter core.
  typedef struct packed {
    logic counter_overflow;
    logic alarm_match_0;
  } tct_core_ev_t;

  // Event outputs toward the event system.
  typedef struct packed {
    logic counter_overflow;
    logic alarm_match_0;
    logic periodic_0;
  } tct_event_t;

endpackage : tct_pkg
`default_nettype wire

// File: logic/tct_timer_regs.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Pulse periodic flag 0 when prescaler bit picked by tap 0 rises.
// - Pulse periodic flag 1 when prescaler bit picked by tap 1 rises.
// - While busy, tap, tuner, event and calendar writes drop and reads give zero.
// - Source codes 0..4 pick RC, 32k, bus clock, generic, 1 kHz tick.
// - Clock enable zero stops the prescaler; one lets it run.
// - Tuner magnitude zero leaves the rate alone; 1..255 corrects it.
// - Direction zero drops one tick in every N plus one.
// - Direction one adds one count in every N minus one ticks.
// - Writing one to event-set bit sets that mask bit; zero does nothing.
// - Writing one to event-clear bit clears that mask bit; zero does nothing.
// - Mask bits at 0, 8, 16 gate overflow, alarm and periodic events.
// - Leap year exactly when the two low year bits are zero.
// - Day counts from one; month runs one to twelve.
// - Hour holds 0 to 23 only.
// - Minute and second hold 0 to 59 only.
// - Fixed taps are reported and ignore writes.
// - Fixed tuner exponent is reported and ignores writes.
// - Parameter register reports periodic comparator count code.
// - Parameter register reports alarm comparator count code.
// - Parameter register reports tuner presence.
// - Instance has one alarm, one periodic comparator, and the tuner.

module tct_timer_regs (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_busy,
  input wire logic [4:0] i_tap0_select,
  input wire logic i_tick_rc_sys,
  input wire logic i_tick_osc_32k,
  input wire logic i_tick_generic,
  input wire logic i_tick_one_khz,
  input wire tct_pkg::tct_core_ev_t i_core_ev,
  output tct_pkg::tct_event_t o_event,
  output logic o_periodic_flag_0,
  output logic o_periodic_flag_1,
  output logic [31:0] o_prescaler,
  output logic [31:0] o_calendar,
  output logic o_leap_year
);

  ////////////////////////////////////////////////////////////////////////////////
  // The whole block state in one record. Keeping every flop in one struct
  // means the reset branch clears all of it with one constant, so nothing
  // can be left out of reset by accident.
  // The read data word lives here too, so the answer comes from a flop and
  // not from a mux hanging off the address pins.
  typedef struct packed {
    logic [31:0] presc;
    logic [tct_pkg::TUNE_CNT_W-1:0] tune_cnt;
    logic [4:0] tap1;
    logic [2:0] src;
    logic clk_en;
    logic [7:0] mag;
    logic add;
    logic [4:0] expo;
    logic [31:0] ev_mask;
    logic [31:0] cal;
    logic [31:0] rdata;
    logic tap0_prev;
    logic tap1_prev;
    logic periodic_flag_0;
    logic periodic_flag_1;
    tct_pkg::tct_event_t ev;
  } tct_state_t;

  tct_state_t state_reg;
  tct_state_t state_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.
  // Arithmetic and range checks are kept out of the main next-state process.

  // Tuner period N = ceil(256 / magnitude) * 2^exponent.
  // The ceiling is taken as (256 + magnitude - 1) / magnitude, which fits
  // in nine bits for every magnitude from 1 to 255.
  // The result is forty bits wide so that the largest quotient shifted by
  // the largest exponent still fits without wrapping.
  function automatic logic [tct_pkg::TUNE_CNT_W-1:0] tct_period(input logic [7:0] mag,
                                                                input logic [4:0] expo);
    logic [8:0] num;
    logic [8:0] q;
    num = 9'h100 + {1'b0, mag} - 9'h001;
    q = (mag == 8'h00) ? 9'h000 : num / {1'b0, mag};
    return {{(tct_pkg::TUNE_CNT_W - 9){1'b0}}, q} << expo;
  endfunction

  // A calendar word is legal only if every field sits in its range.
  // The year has no range of its own, and the day is not held against the
  // length of the month: that belongs to the rollover logic.
  function automatic logic tct_cal_ok(input logic [31:0] w);
    logic [5:0] sec;
    logic [5:0] min;
    logic [4:0] hour;
    logic [4:0] day;
    logic [3:0] mon;
    sec = w[tct_pkg::SEC_LSB +: 6];
    min = w[tct_pkg::MIN_LSB +: 6];
    hour = w[tct_pkg::HOUR_LSB +: 5];
    day = w[tct_pkg::DAY_LSB +: 5];
    mon = w[tct_pkg::MON_LSB +: 4];
    return (sec <= tct_pkg::SEC_MAX) && (min <= tct_pkg::MIN_MAX) &&
           (hour <= tct_pkg::HOUR_MAX) && (day >= tct_pkg::DAY_MIN) &&
           (mon >= tct_pkg::MON_MIN) && (mon <= tct_pkg::MON_MAX);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Combinational views of the configuration.
  // These are plain wires; none of them holds state.

  logic src_tick;
  logic presc_tick;
  logic [4:0] tap0_eff;
  logic [4:0] tap1_eff;
  logic [tct_pkg::TUNE_CNT_W-1:0] tune_n;
  logic [31:0] param_word;

  // Prescaler source mux; an unused code gives no ticks at all.
  // The bus clock source needs no tick input, since this block already
  // runs on the bus clock; every cycle counts.
  // Codes five to seven act as a stopped clock rather than being aliased
  // onto a real source, so a bad write can never speed the count up.
  always_comb
  begin
    case (state_reg.src)
      tct_pkg::SRC_RC_SYS: src_tick = i_tick_rc_sys;
      tct_pkg::SRC_OSC_32K: src_tick = i_tick_osc_32k;
      tct_pkg::SRC_BUS_CLK: src_tick = 1'b1;
      tct_pkg::SRC_GENERIC: src_tick = i_tick_generic;
      tct_pkg::SRC_ONE_KHZ: src_tick = i_tick_one_khz;
      default: src_tick = 1'b0;
    endcase
  end

  // The enable gates the selected source before anything counts.
  // Switching source with the enable high may shorten one tick, so
  // software is expected to stop the clock first.
  assign presc_tick = src_tick & state_reg.clk_en;

  // A non-writable tap follows its fixed value, not the stored field.
  assign tap0_eff = tct_pkg::TAP0_WRITABLE ? i_tap0_select : tct_pkg::TAP0_FIXED;
  assign tap1_eff = tct_pkg::TAP1_WRITABLE ? state_reg.tap1 : tct_pkg::TAP1_FIXED;

  // The tuner period follows the stored fields every cycle; it only
  // matters in a cycle with a pending tick.
  assign tune_n = tct_period(state_reg.mag, state_reg.expo);

  // Parameter word built from the instance configuration.
  // It is pure wiring of constants, so it reads the same during busy and
  // needs no reset.
  always_comb
  begin
    param_word = 32'h00000000;
    param_word[0] = tct_pkg::TUNER_PRESENT;
    param_word[1] = tct_pkg::EXP_WRITABLE;
    param_word[6:2] = tct_pkg::EXP_FIXED;
    param_word[9:8] = tct_pkg::ALARM_COUNT_CODE;
    param_word[12] = tct_pkg::PERIODIC_COUNT_CODE;
    param_word[14] = tct_pkg::TAP0_WRITABLE;
    param_word[15] = tct_pkg::TAP1_WRITABLE;
    param_word[20:16] = tct_pkg::TAP0_FIXED;
    param_word[28:24] = tct_pkg::TAP1_FIXED;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  // One process computes every next value; fields that nothing touches in a
  // cycle keep their value through the copy on its first lines.
  always_comb
  begin
    logic tap0_now;
    logic tap1_now;
    logic [31:0] rd;
    tap0_now = 1'b0;
    tap1_now = 1'b0;
    rd = 32'h00000000;
    state_next = state_reg;

    // Prescaler with digital tuning. Dropping or doubling single counts keeps
    // the long-run rate exact without a fractional accumulator.
    // The phase counter restarts whenever the tuner register is written, so
    // a new setting takes effect from a known phase.
    if (presc_tick)
    begin
      if (state_reg.mag == 8'h00)
      begin
        state_next.presc = state_reg.presc + 32'h00000001;
        state_next.tune_cnt = '0;
      end
      else if (!state_reg.add)
      begin
        // One tick in every N + 1 is swallowed.
        if (state_reg.tune_cnt >= tune_n)
        begin
          state_next.tune_cnt = '0;
        end
        else
        begin
          state_next.tune_cnt = state_reg.tune_cnt + 1'b1;
          state_next.presc = state_reg.presc + 32'h00000001;
        end
      end
      else
      begin
        // Every N - 1 ticks one extra count is inserted.
        if (state_reg.tune_cnt >= tune_n - 2'd2)
        begin
          state_next.tune_cnt = '0;
          state_next.presc = state_reg.presc + 32'h00000002;
        end
        else
        begin
          state_next.tune_cnt = state_reg.tune_cnt + 1'b1;
          state_next.presc = state_reg.presc + 32'h00000001;
        end
      end
    end

    // Periodic taps: edge is taken from the committed prescaler value.
    // Taking the edge from the registered count costs one cycle of latency
    // but keeps the flag off the same-cycle write path.
    // A tap moved by software can raise one extra flag on the move.
    tap0_now = state_reg.presc[tap0_eff];
    tap1_now = state_reg.presc[tap1_eff];
    state_next.tap0_prev = tap0_now;
    state_next.tap1_prev = tap1_now;
    state_next.periodic_flag_0 = tap0_now & ~state_reg.tap0_prev;
    state_next.periodic_flag_1 = tap1_now & ~state_reg.tap1_prev;

    // Events toward the event system, each gated by its mask bit.
    // The mask is applied at the source, so a disabled event never leaves
    // the block, not even for one cycle.
    state_next.ev.counter_overflow =
      i_core_ev.counter_overflow & state_reg.ev_mask[tct_pkg::EV_OVF_BIT];
    state_next.ev.alarm_match_0 =
      i_core_ev.alarm_match_0 & state_reg.ev_mask[tct_pkg::EV_ALARM_BIT];
    state_next.ev.periodic_0 =
      state_next.periodic_flag_0 & state_reg.ev_mask[tct_pkg::EV_PER_BIT];

    // Register writes. Writes during busy are dropped so that a half-synced
    // value never reaches the slow domain.
    // Each register is decoded once here; reserved bits of a written word
    // are simply never copied into state.
    if (i_wr && !i_busy)
    begin
      case (i_addr)
        tct_pkg::OFS_TAP1:
        begin
          if (tct_pkg::TAP1_WRITABLE)
          begin
            state_next.tap1 = i_wdata[tct_pkg::TAP_W-1:0];
          end
        end
        tct_pkg::OFS_CLOCK:
        begin
          state_next.clk_en = i_wdata[tct_pkg::CLK_EN_BIT];
          state_next.src = i_wdata[tct_pkg::SRC_LSB +: tct_pkg::SRC_W];
        end
        tct_pkg::OFS_TUNER:
        begin
          state_next.mag = i_wdata[tct_pkg::MAG_LSB +: tct_pkg::MAG_W];
          state_next.add = i_wdata[tct_pkg::ADD_BIT];
          if (tct_pkg::EXP_WRITABLE)
          begin
            state_next.expo = i_wdata[tct_pkg::EXP_LSB +: tct_pkg::EXP_W];
          end
          // Restart the tuner phase so the new period starts cleanly.
          state_next.tune_cnt = '0;
        end
        tct_pkg::OFS_EV_SET:
        begin
          state_next.ev_mask = state_reg.ev_mask |
                               (i_wdata & tct_pkg::EV_MASK_BITS);
        end
        tct_pkg::OFS_EV_CLR:
        begin
          state_next.ev_mask = state_reg.ev_mask &
                               ~(i_wdata & tct_pkg::EV_MASK_BITS);
        end
        tct_pkg::OFS_CALENDAR:
        begin
          // An out-of-range field would corrupt the rollover, so the whole
          // word is refused rather than stored partly.
          if (tct_cal_ok(i_wdata))
          begin
            state_next.cal = i_wdata;
          end
        end
        default:
        begin
          // Unmapped and read-only offsets ignore the write.
        end
      endcase
    end

    // Register reads, answered in the following cycle.
    // Read data fall back to zero after the answer cycle, so a bus that ORs
    // several slaves together sees only the addressed one.
    if (i_rd)
    begin
      case (i_addr)
        // A fixed tap reads back its fixed value, never the written one.
        tct_pkg::OFS_TAP1: rd = {27'h0, tap1_eff};
        tct_pkg::OFS_CLOCK:
        begin
          rd[tct_pkg::CLK_EN_BIT] = state_reg.clk_en;
          rd[tct_pkg::SRC_LSB +: tct_pkg::SRC_W] = state_reg.src;
        end
        tct_pkg::OFS_TUNER:
        begin
          rd[tct_pkg::MAG_LSB +: tct_pkg::MAG_W] = state_reg.mag;
          rd[tct_pkg::ADD_BIT] = state_reg.add;
          rd[tct_pkg::EXP_LSB +: tct_pkg::EXP_W] =
            tct_pkg::EXP_WRITABLE ? state_reg.expo : tct_pkg::EXP_FIXED;
        end
        tct_pkg::OFS_EV_STATE: rd = state_reg.ev_mask;
        tct_pkg::OFS_CALENDAR: rd = state_reg.cal;
        tct_pkg::OFS_PARAMS: rd = param_word;
        tct_pkg::OFS_REVISION: rd = tct_pkg::REVISION_VALUE;
        default: rd = 32'h00000000;
      endcase
      // Busy hides everything except the two identity registers.
      // Those two are constants, so showing them during busy loses nothing.
      if (i_busy && (i_addr != tct_pkg::OFS_PARAMS) &&
          (i_addr != tct_pkg::OFS_REVISION))
      begin
        rd = 32'h00000000;
      end
    end
    state_next.rdata = rd;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.
  // Reset loads constants only: the whole record goes to zero.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, straight from the state register except the leap year flag.
  // Only the leap year flag is combinational, a compare on the two low year
  // bits of the calendar flops.
  assign o_rdata = state_reg.rdata;
  assign o_event = state_reg.ev;
  assign o_periodic_flag_0 = state_reg.periodic_flag_0;
  assign o_periodic_flag_1 = state_reg.periodic_flag_1;
  assign o_prescaler = state_reg.presc;
  assign o_calendar = state_reg.cal;
  // Leap year test looks only at the two low year bits.
  // It is only right when the year field counts from a leap year base;
  // choosing that base is left to software.
  assign o_leap_year = (state_reg.cal[tct_pkg::YEAR_LSB +: 2] == 2'h0);

endmodule // tct_timer_regs
`default_nettype wire

// File: tb/tct_timer_regs_properties.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level checks on the timer register block.
module tct_timer_regs_properties (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic i_busy,
  input wire logic [4:0] i_tap0_select,
  input wire tct_pkg::tct_core_ev_t i_core_ev,
  input wire logic [31:0] o_rdata,
  input wire tct_pkg::tct_event_t o_event,
  input wire logic o_periodic_flag_0,
  input wire logic o_periodic_flag_1,
  input wire logic [31:0] o_prescaler,
  input wire logic [31:0] o_calendar,
  input wire logic o_leap_year
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  // Read data must be quiet outside the answer cycle, or stale data leaks.
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("Read data not zero outside an answer.");
  params_word_a: assert property (i_rd && i_addr == tct_pkg::OFS_PARAMS |=>
    o_rdata == 32'h00004103) else $error("Parameter word wrong.");
  busy_read_a: assert property (i_rd && i_busy && i_addr != tct_pkg::OFS_PARAMS &&
    i_addr != tct_pkg::OFS_REVISION |=> o_rdata == 32'h0) else $error("Busy read not zero.");
  leap_year_a: assert property (o_leap_year == (o_calendar[27:26] == 2'h0))
    else $error("Leap year flag wrong.");
  time_range_a: assert property (o_calendar[5:0] <= 6'h3b && o_calendar[11:6] <= 6'h3b &&
    o_calendar[16:12] <= 5'h17) else $error("Calendar time out of range.");
  ovf_cause_a: assert property (o_event.counter_overflow |->
    $past(i_core_ev.counter_overflow)) else $error("Overflow event without cause.");
  alarm_cause_a: assert property (o_event.alarm_match_0 |->
    $past(i_core_ev.alarm_match_0)) else $error("Alarm event without cause.");
  per_event_a: assert property (o_event.periodic_0 |-> o_periodic_flag_0)
    else $error("Periodic event without flag.");
  flag0_rise_a: assert property ($rose(o_prescaler[i_tap0_select]) && $stable(i_tap0_select)
    |=> o_periodic_flag_0) else $error("Flag 0 missed a tap rise.");
  flag1_rise_a: assert property ($rose(o_prescaler[0]) |=> o_periodic_flag_1)
    else $error("Flag 1 missed a tap rise.");

  // Main scenarios seen.
  cover property (o_event.counter_overflow);
  cover property (o_periodic_flag_0);
  cover property (i_rd && i_busy);
endmodule // tct_timer_regs_properties

bind tct_timer_regs tct_timer_regs_properties props_u (.i_clk, .i_rst_n, .i_addr, .i_rd,
  .i_busy, .i_tap0_select, .i_core_ev, .o_rdata, .o_event, .o_periodic_flag_0,
  .o_periodic_flag_1, .o_prescaler, .o_calendar, .o_leap_year);
`default_nettype wire

// File: tb/timer_calendar_tuner_events_test.sv
`timescale 1ns/1ns
`default_nettype none
module timer_calendar_tuner_events_test;
  logic clk, rst_n, wr, rd, busy, t_rc, t_osc, t_gen, t_khz, f0, f1, leap;
  logic [7:0] addr;
  logic [4:0] tap0;
  logic [31:0] wdata, rdata, pre, cal, p, good;
  tct_pkg::tct_core_ev_t core_ev;
  tct_pkg::tct_event_t ev;
  int fail_count, num_checks;

  tct_timer_regs dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_busy(busy), .i_tap0_select(tap0),
    .i_tick_rc_sys(t_rc), .i_tick_osc_32k(t_osc), .i_tick_generic(t_gen),
    .i_tick_one_khz(t_khz), .i_core_ev(core_ev), .o_event(ev), .o_periodic_flag_0(f0),
    .o_periodic_flag_1(f1), .o_prescaler(pre), .o_calendar(cal), .o_leap_year(leap));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock of 10 ns.
  always #5 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // Bus cycles; strobes are one cycle and never overlap.
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  function automatic logic [31:0] cw(input logic [5:0] y, input logic [3:0] m,
    input logic [4:0] d, input logic [4:0] h, input logic [5:0] n, input logic [5:0] s);
    return {y, m, d, h, n, s};
  endfunction

  // Separated tick pulses: rc 1, 32k 2, generic 3, 1 kHz 4, so each code has its own count.
  task automatic ticks();
    for (int k = 1; k <= 4; k++)
    begin
      @(posedge clk);
      t_rc <= (k <= 1); t_osc <= (k <= 2); t_gen <= (k <= 3); t_khz <= 1'b1;
      @(posedge clk);
      t_rc <= 1'b0; t_osc <= 1'b0; t_gen <= 1'b0; t_khz <= 1'b0;
    end
    #1;
  endtask

  task automatic test_reset();
    rc(tct_pkg::OFS_TAP1, 32'h0);
    rc(tct_pkg::OFS_CLOCK, 32'h0);
    rc(tct_pkg::OFS_TUNER, 32'h0);
    rc(tct_pkg::OFS_EV_STATE, 32'h0);
    rc(tct_pkg::OFS_CALENDAR, 32'h0);
    rc(tct_pkg::OFS_PARAMS, 32'h00004103);
    rc(tct_pkg::OFS_REVISION, tct_pkg::REVISION_VALUE);
    bw(8'h60, 32'hffffffff);
    rc(8'h60, 32'h0);
    bw(tct_pkg::OFS_TAP1, 32'h0000001f);
    rc(tct_pkg::OFS_TAP1, 32'h0);
    $display("reset test done");
  endtask

  task automatic test_clock();
    logic [2:0] codes [5];
    logic [31:0] cnt [5];
    codes = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
    cnt = '{32'h1, 32'h2, 32'h3, 32'h4, 32'h0};
    bw(tct_pkg::OFS_CLOCK, 32'hfffffa01);
    rc(tct_pkg::OFS_CLOCK, 32'h00000201);
    p = pre;
    repeat (10) @(posedge clk);
    #1 chk(pre, p + 32'ha);
    for (int i = 0; i < 5; i++)
    begin
      bw(tct_pkg::OFS_CLOCK, {21'h0, codes[i], 8'h01});
      @(posedge clk);
      #1 p = pre;
      ticks();
      chk(pre, p + cnt[i]);
    end
    // A stopped clock must hold the count even with ticks every cycle.
    bw(tct_pkg::OFS_CLOCK, 32'h00000200);
    @(posedge clk);
    #1 p = pre;
    repeat (10) @(posedge clk);
    #1 chk(pre, p);
    $display("clock test done");
  endtask

  task automatic test_tuner();
    logic [31:0] w [2];
    logic [31:0] e [2];
    w = '{32'h00004000, 32'h00004020};
    e = '{32'h18, 32'h28};
    bw(tct_pkg::OFS_TUNER, 32'hffffffff);
    rc(tct_pkg::OFS_TUNER, 32'h0000ff3f);
    bw(tct_pkg::OFS_CLOCK, 32'h00000201);
    // Magnitude 64 gives N of 4; 30 cycles hold whole drop and add periods.
    for (int i = 0; i < 2; i++)
    begin
      bw(tct_pkg::OFS_TUNER, w[i]);
      @(posedge clk);
      #1 p = pre;
      repeat (30) @(posedge clk);
      #1 chk(pre, p + e[i]);
    end
    bw(tct_pkg::OFS_CLOCK, 32'h00000200);
    bw(tct_pkg::OFS_TUNER, 32'h0);
    $display("tuner test done");
  endtask

  task automatic test_events();
    bw(tct_pkg::OFS_EV_SET, 32'hffffffff);
    rc(tct_pkg::OFS_EV_STATE, 32'h00010101);
    bw(tct_pkg::OFS_EV_CLR, 32'h0);
    rc(tct_pkg::OFS_EV_STATE, 32'h00010101);
    bw(tct_pkg::OFS_EV_CLR, 32'h00000100);
    rc(tct_pkg::OFS_EV_STATE, 32'h00010001);
    @(posedge clk);
    core_ev <= 2'h3;
    @(posedge clk);
    core_ev <= 2'h0;
    #1 chk({30'h0, ev[2:1]}, 32'h2);
    $display("event test done");
  endtask

  task automatic test_busy();
    @(posedge clk);
    busy <= 1'b1;
    bw(tct_pkg::OFS_CLOCK, 32'h00000001);
    bw(tct_pkg::OFS_EV_CLR, 32'hffffffff);
    rc(tct_pkg::OFS_CLOCK, 32'h0);
    rc(tct_pkg::OFS_EV_STATE, 32'h0);
    rc(tct_pkg::OFS_PARAMS, 32'h00004103);
    @(posedge clk);
    busy <= 1'b0;
    rc(tct_pkg::OFS_CLOCK, 32'h00000200);
    rc(tct_pkg::OFS_EV_STATE, 32'h00010001);
    $display("busy test done");
  endtask

  task automatic test_calendar();
    logic [31:0] bad [6];
    bad = '{cw(6'h5, 4'hc, 5'h1f, 5'h18, 6'h0, 6'h0), cw(6'h5, 4'hc, 5'h1f, 5'h0, 6'h3c, 6'h0),
      cw(6'h5, 4'hc, 5'h1f, 5'h0, 6'h0, 6'h3c), cw(6'h5, 4'hd, 5'h1, 5'h0, 6'h0, 6'h0),
      cw(6'h5, 4'h1, 5'h0, 5'h0, 6'h0, 6'h0), cw(6'h5, 4'h0, 5'h1, 5'h0, 6'h0, 6'h0)};
    good = cw(6'h5, 4'hc, 5'h1f, 5'h17, 6'h3b, 6'h3b);
    bw(tct_pkg::OFS_CALENDAR, good);
    rc(tct_pkg::OFS_CALENDAR, good);
    chk(cal, good);
    chk({31'h0, leap}, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      bw(tct_pkg::OFS_CALENDAR, bad[i]);
      rc(tct_pkg::OFS_CALENDAR, good);
    end
    bw(tct_pkg::OFS_CALENDAR, cw(6'h8, 4'h2, 5'h1d, 5'h0, 6'h0, 6'h0));
    #1 chk({31'h0, leap}, 32'h1);
    $display("calendar test done");
  endtask

  // Free-running bus clock count; a 16-cycle window after two settling cycles
  // holds exactly 16 increments, so bit 2 rises twice and bit 0 eight times.
  task automatic test_periodic();
    int n0;
    int n1;
    int ne;
    for (int r = 0; r < 2; r++)
    begin
      if (r == 0)
        bw(tct_pkg::OFS_CLOCK, 32'h00000201);
      else
        bw(tct_pkg::OFS_EV_CLR, 32'h00010000);
      repeat (2) @(posedge clk);
      n0 = 0;
      n1 = 0;
      ne = 0;
      repeat (16)
      begin
        @(posedge clk);
        #1;
        n0 += f0;
        n1 += f1;
        ne += ev[0];
      end
      chk(n0, 32'h2);
      chk(n1, 32'h8);
      chk(ne, (r == 0) ? 32'h2 : 32'h0);
    end
    bw(tct_pkg::OFS_CLOCK, 32'h00000200);
    $display("periodic test done");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; the calendar write lands on the edge that ends its strobe, checked by the #1 in test_calendar.
  initial
  begin
    clk = 1'b0; rst_n = 1'b0; wr = 1'b0; rd = 1'b0; busy = 1'b0; addr = 8'h0;
    wdata = 32'h0; tap0 = 5'h2; t_rc = 1'b0; t_osc = 1'b0; t_gen = 1'b0; t_khz = 1'b0;
    core_ev = 2'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    test_reset();
    test_clock();
    test_tuner();
    test_events();
    test_busy();
    test_calendar();
    test_periodic();
    conclude();
  end

  // Watchdog well beyond the few hundred cycles the tests need.
  initial
  begin
    #100000;
    fail_count++;
    conclude();
  end
endmodule // timer_calendar_tuner_events_test
`default_nettype wire
